// [hdl/pwk_wake_ctrl.sv]
// pwk_wake_ctrl: wake-event collection, PME signalling and low-power
// gating of the embedded PHY and medium access unit.
// assumes all event inputs and pins are synchronous to sys_clk and the
// registers are reached by one AHB-Lite master doing single word transfers.
//
// Our own choices: the AHB-Lite register port and the address map.
`timescale 1ns/1ns
`default_nettype none

module pwk_wake_ctrl
  import pwk_pkg::*;
#(
  parameter int SRC_COUNT = PWK_NUM_SRC
) (
  // clock and resets
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic aux_power_on_reset_n,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // fixed filter hits, crystal-clock side
  input wire logic iaMatchHit,
  input wire logic mcMatchHit,
  input wire logic arpHit,
  input wire logic wakePatternHit,
  // flexible filter hit and pci clock status
  input wire logic flexFilterHit,
  input wire logic pciClkValid,
  // link and supply status
  input wire logic linkUp,
  input wire logic aux_power_indicator,
  input wire logic mainPowerOff,
  input wire logic wake_on_lan_setting,
  // pme open-drain pin
  output logic pmeOut,
  output logic pmeOe,
  // interrupt and power gating
  output logic irq,
  output logic phyPowerDown,
  output logic macLowPower
);

  // ==========================================================
  // address decode, shared by read and write paths
  function automatic pwk_reg_e decodeReg(input logic [7:0] addr);
    pwk_reg_e r;
    r = PWK_REG_NONE;
    unique case (addr)
      PWK_OFS_PMCSR: r = PWK_REG_PMCSR;
      PWK_OFS_WAKECFG: r = PWK_REG_WAKECFG;
      PWK_OFS_PMCAP: r = PWK_REG_PMCAP;
      PWK_OFS_EVSTAT: r = PWK_REG_EVSTAT;
      PWK_OFS_EVMASK: r = PWK_REG_EVMASK;
      PWK_OFS_LIVE: r = PWK_REG_LIVE;
      default: r = PWK_REG_NONE;
    endcase
    return r;
  endfunction

  // ==========================================================
  // state record
  pwk_state_s st_q;
  pwk_state_s st_d;

  // combinational helpers
  logic addrPhase;
  logic [7:0] aAddr;
  logic [SRC_COUNT-1:0] rawHit;
  logic [SRC_COUNT-1:0] srcAllowed;
  logic [SRC_COUNT-1:0] wakeHits;
  logic wakeAny;
  logic wolBypass;
  logic d3Cold;
  logic flexOk;
  logic fixedOk;
  logic [4:0] supportField;
  logic [31:0] readWord;
  pwk_reg_e wReg;
  pwk_reg_e rReg;

  // ==========================================================
  // wake qualification
  // fixed hits arrive already resolved on the crystal-clock side and the
  // pci clock never gates them, so they work on aux supply alone
  always_comb begin
    aAddr = {haddr[7:2], 2'b00};
    addrPhase = hsel && htrans[1] && hready;
    rawHit = '0;
    rawHit[PWK_SRC_IA] = iaMatchHit;
    rawHit[PWK_SRC_MC] = mcMatchHit;
    rawHit[PWK_SRC_ARP] = arpHit;
    rawHit[PWK_SRC_PATTERN] = wakePatternHit;
    rawHit[PWK_SRC_LINK] = linkUp && !st_q.linkPrev;
    rawHit[PWK_SRC_FLEX] = flexFilterHit;
    d3Cold = (st_q.pState == PWK_D3) && mainPowerOff;
    // fixed and link detection need only the PHY alive and some supply
    fixedOk = !st_q.phyDown && (!d3Cold || st_q.auxPresent);
    // flexible filtering needs the pci clock pin, and in D2 and D3 the external clock enable as well
    flexOk = pciClkValid && !st_q.phyDown;
    unique case (st_q.pState)
      PWK_D0, PWK_D1: flexOk = flexOk;
      PWK_D2: flexOk = flexOk && st_q.extClk;
      PWK_D3: flexOk = flexOk && st_q.extClk && (!mainPowerOff || st_q.auxPresent);
    endcase
    srcAllowed = {SRC_COUNT{fixedOk}};
    srcAllowed[PWK_SRC_FLEX] = flexOk;
    wakeHits = rawHit & srcAllowed & st_q.srcEn;
    wakeAny = |wakeHits;
    // without aux supply, wake-on-lan ignores the enable bit entirely
    wolBypass = wake_on_lan_setting && !st_q.auxPresent;
    supportField = st_q.auxPresent ? PWK_SUPPORT_AUX : PWK_SUPPORT_NO_AUX;
  end

  // ==========================================================
  // next-state logic: bus, pme bits, events, reset handling
  // read data is built from the post-write values so a read that
  // directly follows a write to the same word sees the new value
  always_comb begin
    st_d = st_q;
    readWord = 32'h0000_0000;
    wReg = decodeReg(st_q.dAddr);
    rReg = decodeReg(aAddr);
    st_d.readyOut = 1'b1;
    st_d.linkPrev = linkUp;

    // data phase of a write
    if (st_q.dWrite) begin
      unique case (wReg)
        PWK_REG_PMCSR: begin
          st_d.pState = pwk_dstate_e'(hwdata[PWK_PMCSR_STATE_LSB +: 2]);
          st_d.pmeEn = hwdata[PWK_PMCSR_PMEEN_BIT];
          if (hwdata[PWK_PMCSR_PMESTAT_BIT]) begin
            st_d.pmeStat = 1'b0;
          end
        end
        PWK_REG_WAKECFG: begin
          st_d.srcEn = hwdata[SRC_COUNT-1:0];
          st_d.extClk = hwdata[PWK_WCFG_EXTCLK_BIT];
        end
        PWK_REG_EVMASK: st_d.evMask = hwdata[SRC_COUNT-1:0];
        default: st_d = st_d; // read-only or unmapped: ignored
      endcase
    end

    // read mux on post-write values
    unique case (rReg)
      PWK_REG_PMCSR: begin
        readWord[PWK_PMCSR_STATE_LSB +: 2] = st_d.pState;
        readWord[PWK_PMCSR_PMEEN_BIT] = st_d.pmeEn;
        readWord[PWK_PMCSR_PMESTAT_BIT] = st_d.pmeStat;
      end
      PWK_REG_WAKECFG: begin
        readWord[SRC_COUNT-1:0] = st_d.srcEn;
        readWord[PWK_WCFG_EXTCLK_BIT] = st_d.extClk;
      end
      PWK_REG_PMCAP: readWord[PWK_PMCAP_SUPPORT_LSB +: 5] = supportField;
      PWK_REG_EVSTAT: readWord[SRC_COUNT-1:0] = st_q.evStat;
      PWK_REG_EVMASK: readWord[SRC_COUNT-1:0] = st_d.evMask;
      PWK_REG_LIVE: readWord[5:0] = {wolBypass, st_q.auxPresent, st_q.pmeOe,
                                     linkUp, st_q.macLow, st_q.phyDown};
      default: readWord = 32'h0000_0000;
    endcase

    // address phase: capture, load read data, clear status on read
    st_d.dWrite = addrPhase && hwrite;
    st_d.dAddr = aAddr;
    if (addrPhase && !hwrite) begin
      st_d.rdata = readWord;
      if (rReg == PWK_REG_EVSTAT) begin
        st_d.evStat = '0;
      end
    end

    // events win over a read or write clear in the same cycle
    st_d.evStat = st_d.evStat | wakeHits;
    if (wakeAny) begin
      st_d.pmeStat = 1'b1;
    end

    // pme pin driven while status stands and wake is enabled, in any state
    st_d.pmeOe = st_d.pmeStat && (st_d.pmeEn || wolBypass);
    st_d.irq = |(st_d.evStat & st_d.evMask);

    // power gating follows the new state and enable without delay
    if ((st_d.pState == PWK_D2 || st_d.pState == PWK_D3) && !(st_d.pmeEn || wolBypass)) begin
      st_d.phyDown = 1'b1;
      st_d.macLow = 1'b1;
    end else begin
      st_d.phyDown = 1'b0;
      st_d.macLow = 1'b0;
    end

    // supply sampling one cycle after a reset release
    if (st_q.sampleDue) begin
      st_d.sampleDue = 1'b0;
      st_d.afterPor = 1'b0;
      st_d.auxPresent = !aux_power_indicator;
      if (st_q.afterPor) begin
        st_d.pmeEn = !aux_power_indicator;
        st_d.pmeStat = 1'b0;
        st_d.pmeOe = 1'b0;
      end
    end

    // bus reset keeps the pme bits only when aux supply was seen
    if (rst) begin
      st_d.rdata = PWK_RDATA_RESET;
      st_d.readyOut = 1'b1;
      st_d.dWrite = 1'b0;
      st_d.dAddr = 8'h00;
      st_d.pState = PWK_D0;
      st_d.srcEn = PWK_SRC_RESET;
      st_d.extClk = 1'b0;
      st_d.evStat = PWK_SRC_RESET;
      st_d.evMask = PWK_SRC_RESET;
      st_d.sampleDue = 1'b1;
      st_d.afterPor = 1'b0;
      st_d.linkPrev = 1'b0;
      st_d.irq = 1'b0;
      st_d.phyDown = 1'b0;
      st_d.macLow = 1'b0;
      if (st_q.auxPresent) begin
        st_d.pmeEn = st_q.pmeEn;
        st_d.pmeStat = st_q.pmeStat;
        st_d.pmeOe = st_q.pmeOe;
      end else begin
        st_d.pmeEn = 1'b0;
        st_d.pmeStat = 1'b0;
        st_d.pmeOe = 1'b0;
      end
    end

    // power-on reset clears all but readyOut, sampleDue and afterPor; enable is set after sampling only when aux supply is seen
    if (!aux_power_on_reset_n) begin
      st_d = '0;
      st_d.rdata = PWK_RDATA_RESET;
      st_d.readyOut = 1'b1;
      st_d.pState = PWK_D0;
      st_d.sampleDue = 1'b1;
      st_d.afterPor = 1'b1;
    end
  end

  // ==========================================================
  // single state register
  always_ff @(posedge sys_clk) begin
    st_q <= st_d;
  end

  // ==========================================================
  // outputs straight from the state register; hresp and pmeOut are tied to 0
  // the pin level is always low; only its enable moves (open drain)
  assign hreadyout = st_q.readyOut;
  assign hresp = 1'b0;
  assign hrdata = st_q.rdata;
  assign pmeOut = 1'b0;
  assign pmeOe = st_q.pmeOe;
  assign irq = st_q.irq;
  assign phyPowerDown = st_q.phyDown;
  assign macLowPower = st_q.macLow;

endmodule

`default_nettype wire

// [shared/pwk_pkg.sv]
// pwk_pkg: register map, field positions, reset values and state record
// of the wake-event and power-gating block.
// assumes a 32-bit AHB-Lite slave with word-aligned registers.
package pwk_pkg;

  // ==========================================================
  // register byte offsets
  localparam logic [7:0] PWK_OFS_PMCSR = 8'h00;
  localparam logic [7:0] PWK_OFS_WAKECFG = 8'h04;
  localparam logic [7:0] PWK_OFS_PMCAP = 8'h08;
  localparam logic [7:0] PWK_OFS_EVSTAT = 8'h0C;
  localparam logic [7:0] PWK_OFS_EVMASK = 8'h10;
  localparam logic [7:0] PWK_OFS_LIVE = 8'h14;

  // ==========================================================
  // field positions
  localparam int PWK_PMCSR_STATE_LSB = 0;
  localparam int PWK_PMCSR_PMEEN_BIT = 8;
  localparam int PWK_PMCSR_PMESTAT_BIT = 15;
  localparam int PWK_WCFG_EXTCLK_BIT = 8;
  localparam int PWK_PMCAP_SUPPORT_LSB = 11;
  localparam int PWK_NUM_SRC = 6;
  // wake source indices inside enable, status and mask words
  localparam int PWK_SRC_IA = 0;
  localparam int PWK_SRC_MC = 1;
  localparam int PWK_SRC_ARP = 2;
  localparam int PWK_SRC_PATTERN = 3;
  localparam int PWK_SRC_LINK = 4;
  localparam int PWK_SRC_FLEX = 5;

  // ==========================================================
  // values
  localparam logic [4:0] PWK_SUPPORT_NO_AUX = 5'h0F;
  localparam logic [4:0] PWK_SUPPORT_AUX = 5'h1F;
  localparam logic [5:0] PWK_SRC_RESET = 6'h00;
  localparam logic [31:0] PWK_RDATA_RESET = 32'h0000_0000;

  // ==========================================================
  // types
  typedef enum logic [1:0] {PWK_D0, PWK_D1, PWK_D2, PWK_D3} pwk_dstate_e;

  typedef enum logic [2:0] {
    PWK_REG_PMCSR, PWK_REG_WAKECFG, PWK_REG_PMCAP,
    PWK_REG_EVSTAT, PWK_REG_EVMASK, PWK_REG_LIVE, PWK_REG_NONE
  } pwk_reg_e;

  // whole state of the block, registered in one place
  typedef struct packed {
    logic [31:0] rdata;
    logic readyOut;
    logic dWrite;
    logic [7:0] dAddr;
    pwk_dstate_e pState;
    logic pmeEn;
    logic pmeStat;
    logic [PWK_NUM_SRC-1:0] srcEn;
    logic extClk;
    logic [PWK_NUM_SRC-1:0] evStat;
    logic [PWK_NUM_SRC-1:0] evMask;
    logic auxPresent;
    logic sampleDue;
    logic afterPor;
    logic linkPrev;
    logic pmeOe;
    logic irq;
    logic phyDown;
    logic macLow;
  } pwk_state_s;

endpackage

// [testbench/pwk_host_model.sv]
// pwk_host_model: host side of the open-drain wake pin.
// assumes the pin has a pull-up on the host board.
`timescale 1ns/1ns
`default_nettype none
module pwk_host_model (
  // pin as driven by the device
  input wire logic pmeOut,
  input wire logic pmeOe,
  // level the host sees
  output logic pmeLine
);
  // pull-up wins whenever nobody drives
  assign pmeLine = pmeOe ? pmeOut : 1'b1;
endmodule
`default_nettype wire

// [testbench/pwk_wake_checker.sv]
// pwk_wake_checker: port-level checks of the wake block.
// assumes one sys_clk domain; either reset silences the checks.
`timescale 1ns/1ns
`default_nettype none
module pwk_wake_checker import pwk_pkg::*; (
  // clock, resets, bus
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic aux_power_on_reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  // events
  input wire logic iaMatchHit,
  input wire logic mcMatchHit,
  input wire logic arpHit,
  input wire logic wakePatternHit,
  input wire logic flexFilterHit,
  input wire logic linkUp,
  input wire logic wake_on_lan_setting,
  // outputs
  input wire logic pmeOut,
  input wire logic pmeOe,
  input wire logic irq,
  input wire logic phyPowerDown,
  input wire logic macLowPower
);
  // ==========================================
  // data-phase markers, since hwdata lags its address by a cycle
  logic wrReq;
  logic wrAny_q;
  logic wrPm_q;
  logic hitAny;
  assign wrReq = hsel && htrans[1] && hready && hwrite;
  assign hitAny = iaMatchHit | mcMatchHit | arpHit | wakePatternHit | flexFilterHit;
  always_ff @(posedge sys_clk) begin
    wrAny_q <= wrReq;
    wrPm_q <= wrReq && (haddr[7:2] == PWK_OFS_PMCSR[7:2]);
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst || !aux_power_on_reset_n);

  a_pin_level: assert property (pmeOe |-> pmeOut == 1'b0)
    else $error("pme driven high");
  a_pme_cause: assert property ($rose(pmeOe) |-> $past(hitAny || linkUp || wrPm_q))
    else $error("pme without cause");
  a_pme_hold: assert property ($fell(pmeOe) |-> $past(wrPm_q && hwdata[15]))
    else $error("pme dropped early");
  a_irq_cause: assert property ($rose(irq) |-> $past(hitAny || linkUp || wrAny_q))
    else $error("irq without cause");
  a_mac_follow: assert property (phyPowerDown == macLowPower)
    else $error("mac and phy differ");
  a_low_d23: assert property (wrPm_q && hwdata[1] && !hwdata[8] && !wake_on_lan_setting |=> phyPowerDown)
    else $error("phy not off");
  a_d1_awake: assert property (wrPm_q && hwdata[1:0] == 2'h1 |=> !phyPowerDown && !macLowPower)
    else $error("d1 not powered");
  a_enable_wakes: assert property (wrPm_q && hwdata[8] |=> !phyPowerDown)
    else $error("phy not restored");
  a_gate_by_write: assert property ($changed(phyPowerDown) |-> $past(wrPm_q))
    else $error("gating without write");
endmodule
bind pwk_wake_ctrl pwk_wake_checker u_pwk_wake_checker (.*);
`default_nettype wire

// [testbench/pwk_wake_ctrl_tb_top.sv]
// pwk_wake_ctrl_tb_top: self-checking bench of the wake block.
// assumes the host pin model and the bound checker are compiled first.
`timescale 1ns/1ns
`default_nettype none
module pwk_wake_ctrl_tb_top import pwk_pkg::*; ();
  typedef struct packed {logic [5:0] src; logic [5:0] mask; logic irqE;} pwk_row_s;
  logic sys_clk = 1'b0;
  logic rst, aux_power_on_reset_n, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rdv;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic iaMatchHit, mcMatchHit, arpHit, wakePatternHit, flexFilterHit, pciClkValid;
  logic linkUp, aux_power_indicator, mainPowerOff, wake_on_lan_setting;
  logic pmeOut, pmeOe, irq, phyPowerDown, macLowPower, pmeLine;
  int bad_count = 0;
  int cmp_count = 0;
  // one row per wake source, last row with the interrupt masked
  pwk_row_s rows [7] = '{'{6'h01, 6'h3F, 1'b1}, '{6'h02, 6'h3F, 1'b1}, '{6'h04, 6'h3F, 1'b1},
    '{6'h08, 6'h3F, 1'b1}, '{6'h10, 6'h3F, 1'b1}, '{6'h20, 6'h3F, 1'b1}, '{6'h05, 6'h00, 1'b0}};

  // ==========================================
  // clock, design and host pin
  always #50 sys_clk = ~sys_clk;
  assign hready = hreadyout;
  pwk_wake_ctrl u_pwk_wake_ctrl (.*);
  pwk_host_model u_pwk_host_model (.pmeOut(pmeOut), .pmeOe(pmeOe), .pmeLine(pmeLine));

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  // one single transfer; waits on hready, never on a fixed count
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge sys_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hready !== 1'b1);
    rdv = hrdata;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
    bus(1'b0, a, 32'h0);
    chk(n, rdv, e);
    chk("hresp", 32'(hresp), 32'h0);
  endtask
  // link toggles low for a cycle so its rise lands one edge later
  task automatic hit(input logic [5:0] h);
    @(posedge sys_clk);
    {flexFilterHit, linkUp, wakePatternHit, arpHit, mcMatchHit, iaMatchHit} <= {h[5], !h[4], h[3:0]};
    @(posedge sys_clk);
    {flexFilterHit, linkUp, wakePatternHit, arpHit, mcMatchHit, iaMatchHit} <= 6'h10;
    @(posedge sys_clk);
    #1;
  endtask
  task automatic rstp(input logic p);
    @(posedge sys_clk);
    if (p) aux_power_on_reset_n <= 1'b0;
    else rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    aux_power_on_reset_n <= 1'b1;
    rst <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic complete_run();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ==========================================
  // main sequence
  initial begin
    {rst, aux_power_on_reset_n, hsel, hwrite, htrans, haddr, hwdata} = '0;
    rst = 1'b1;
    {iaMatchHit, mcMatchHit, arpHit, wakePatternHit, flexFilterHit} = '0;
    {mainPowerOff, wake_on_lan_setting} = 2'b00;
    {linkUp, pciClkValid, aux_power_indicator} = 3'b111;
    hsize = 3'h2;
    rstp(1'b1);
    rd(PWK_OFS_PMCSR, 32'h0, "pmcsr reset");
    rd(PWK_OFS_PMCAP, 32'h7800, "support");
    bus(1'b1, PWK_OFS_WAKECFG, 32'h13F);
    bus(1'b1, PWK_OFS_PMCSR, 32'h100);
    foreach (rows[i]) begin
      bus(1'b1, PWK_OFS_EVMASK, {26'h0, rows[i].mask});
      hit(rows[i].src);
      chk("pme", 32'(pmeLine), 32'h0);
      chk("irq", 32'(irq), 32'(rows[i].irqE));
      rd(PWK_OFS_EVSTAT, {26'h0, rows[i].src}, "evstat");
      rd(PWK_OFS_EVSTAT, 32'h0, "evstat clear");
      bus(1'b1, PWK_OFS_PMCSR, 32'h8100);
      chk("pme release", 32'(pmeLine), 32'h1);
    end
    $display("source table done");
    bus(1'b1, PWK_OFS_PMCSR, 32'h0);
    hit(6'h04);
    chk("pme disabled", 32'(pmeLine), 32'h1);
    rd(PWK_OFS_PMCSR, 32'h8000, "pme status");
    bus(1'b1, PWK_OFS_PMCSR, 32'h8000);
    wake_on_lan_setting <= 1'b1;
    hit(6'h04);
    chk("pme bypass", 32'(pmeLine), 32'h0);
    bus(1'b1, PWK_OFS_PMCSR, 32'h8000);
    wake_on_lan_setting <= 1'b0;
    rd(PWK_OFS_EVSTAT, 32'h4, "evstat sticky");
    $display("status and bypass done");
    bus(1'b1, PWK_OFS_PMCSR, 32'h2);
    chk("phy off", 32'({phyPowerDown, macLowPower}), 32'h3);
    rd(PWK_OFS_LIVE, 32'h7, "live gated");
    bus(1'b1, PWK_OFS_PMCSR, 32'h3);
    hit(6'h01);
    rd(PWK_OFS_EVSTAT, 32'h0, "gated");
    bus(1'b1, PWK_OFS_PMCSR, 32'h103);
    chk("phy on", 32'(phyPowerDown), 32'h0);
    hit(6'h10);
    chk("link wake", 32'(pmeLine), 32'h0);
    // main supply off in D3 without aux: fixed hits must be ignored
    mainPowerOff <= 1'b1;
    hit(6'h01);
    rd(PWK_OFS_EVSTAT, 32'h10, "d3cold no aux");
    mainPowerOff <= 1'b0;
    bus(1'b1, PWK_OFS_PMCSR, 32'h8001);
    chk("d1 powered", 32'(phyPowerDown), 32'h0);
    bus(1'b1, 8'h1C, 32'hFFFF_FFFF);
    rd(8'h1C, 32'h0, "unmapped");
    bus(1'b1, PWK_OFS_PMCAP, 32'h0);
    rd(PWK_OFS_PMCAP, 32'h7800, "pmcap ro");
    $display("power gating done");
    aux_power_indicator <= 1'b0;
    rstp(1'b1);
    rd(PWK_OFS_PMCSR, 32'h100, "aux por");
    rd(PWK_OFS_PMCAP, 32'hF800, "aux support");
    bus(1'b1, PWK_OFS_WAKECFG, 32'h3F);
    bus(1'b1, PWK_OFS_PMCSR, 32'h103);
    hit(6'h20);
    rd(PWK_OFS_EVSTAT, 32'h0, "flex no clock");
    // external clock present but pci clock missing: flexible hit dropped
    bus(1'b1, PWK_OFS_WAKECFG, 32'h13F);
    pciClkValid <= 1'b0;
    hit(6'h20);
    rd(PWK_OFS_EVSTAT, 32'h0, "flex pci clock");
    // with aux supply both fixed and flexible wake work in D3cold
    pciClkValid <= 1'b1;
    mainPowerOff <= 1'b1;
    hit(6'h21);
    rd(PWK_OFS_EVSTAT, 32'h21, "d3cold aux wake");
    mainPowerOff <= 1'b0;
    hit(6'h01);
    rstp(1'b0);
    rd(PWK_OFS_PMCSR, 32'h8100, "bus reset");
    chk("pme held", 32'(pmeLine), 32'h0);
    $display("aux power done");
    complete_run();
  end

  // watchdog: the whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge sys_clk);
    bad_count++;
    complete_run();
  end
endmodule
`default_nettype wire
